/* File: verification/tb.sv */
// self-checking bench for the table-read / xor execution slice
`timescale 1ns/10ps
`default_nettype none
`include "trx_regs.svh"

module tb;
    import trx_pkg::*;
    logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, rom_rd, zf;
    logic [11:0] s_axi_awaddr, s_axi_araddr, fadr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, r, r2, rv;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [10:0] rom_addr;
    logic [13:0] rom_data;
    logic [5:0]  tdh;
    logic [2:0]  opc;
    trx_byte_t   acc, tph, timer0_mode_reg, fv, imm;
    int          mismatches, n_checks;

    trx_core #(.ROM_AW(11), .FILE_DEPTH(128)) DUT (.*);

    // clock and rom: the word appears the cycle after the strobe, else it keeps moving
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        rom_data <= sys_rst ? 14'h0000 : (rom_rd ? rom_fn(rom_addr) : ~rom_data);
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [13:0] rom_fn(input logic [10:0] a);
        return {a[10:8] ^ 3'h5, a[2:0], a[7:0] ^ 8'hC3};
    endfunction : rom_fn
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    // one axi write; handshakes sampled between edges, released after the taking edge
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_hit, w_hit, b_hit;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        b_hit = 1'b0;
        for (int n = 0; n < 40 && !b_hit; n++) begin
            @(negedge clk);
            aw_hit = s_axi_awvalid & s_axi_awready;
            w_hit  = s_axi_wvalid & s_axi_wready;
            b_hit  = s_axi_bvalid;
            if (b_hit) chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
            @(posedge clk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) s_axi_bready <= 1'b0;
        end
        if (!b_hit) begin
            mismatches++;
            wrap_up();
        end
    endtask : wr
    // one axi read
    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
        logic ar_hit, r_hit;
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        r_hit = 1'b0;
        for (int n = 0; n < 40 && !r_hit; n++) begin
            @(negedge clk);
            ar_hit = s_axi_arvalid & s_axi_arready;
            r_hit  = s_axi_rvalid;
            d      = s_axi_rdata;
            if (r_hit) chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
            @(posedge clk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) s_axi_rready <= 1'b0;
        end
        if (!r_hit) begin
            mismatches++;
            wrap_up();
        end
    endtask : rd
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, `TRX_RESP_OKAY, d);
        chk(nm, d, exp);
    endtask : rchk

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
        {s_axi_wdata, acc, tph, timer0_mode_reg, tdh, zf} = 63'h0;
        s_axi_wstrb = 4'hF;
        seed = 32'h4;
        mismatches = 0;
        n_checks = 0;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        // reset values, refusals, read-only timer mode
        rchk("acc", `TRX_OFS_ACC, 32'h0);
        rchk("tph", `TRX_OFS_TPH, 32'h0);
        rchk("tdh", `TRX_OFS_TDH, 32'h0);
        rchk("status", `TRX_OFS_STATUS, 32'h0);
        rd(12'h100, `TRX_RESP_SLVERR, rv);
        chk("unmapped rdata", rv, 32'h0);
        wr(12'h100, 32'hFFFF_FFFF, `TRX_RESP_SLVERR);
        wr(`TRX_OFS_TIMER0_MODE_REG, 32'h0000_00FF, `TRX_RESP_OKAY);
        rchk("timer0_mode_reg", `TRX_OFS_TIMER0_MODE_REG, 32'h0);
        // first eight walk every code from a zeroing xor-immediate, then random codes
        for (int i = 0; i < 60; i++) begin
            r = xs();
            r2 = xs();
            opc = (i < 8) ? 3'(i + 5) : r2[2:0];
            {acc, tph, fv} = r[23:0];
            imm = (i % 4 == 0) ? acc : r2[15:8];
            fadr = `TRX_OFS_FILE_BASE + {3'h0, r[30:24], 2'h0};
            wr(`TRX_OFS_ACC, {24'h0, acc}, `TRX_RESP_OKAY);
            wr(`TRX_OFS_TPH, {24'h0, tph}, `TRX_RESP_OKAY);
            wr(fadr, {24'hA5A5A5, fv}, `TRX_RESP_OKAY);
            wr(`TRX_OFS_CMD, {8'h0, imm, 1'b0, r[30:24], 4'h0, r[31], opc}, `TRX_RESP_OKAY);
            case (opc)
                `TRX_OP_TABLE_READ:  {tdh, acc} = rom_fn({tph[2:0], acc});
                `TRX_OP_TMODE_READ:  acc = timer0_mode_reg;
                `TRX_OP_TMODE_WRITE: timer0_mode_reg = acc;
                `TRX_OP_XOR_REG:     {fv, acc} = r[31] ? {acc ^ fv, acc} : {fv, acc ^ fv};
                `TRX_OP_XOR_IMM:     {zf, acc} = {(acc ^ imm) == 8'h00, acc ^ imm};
                default:             acc = acc;
            endcase
            // a table read lands two cycles after it executes
            repeat (3) @(posedge clk);
            rchk("acc", `TRX_OFS_ACC, {24'h0, acc});
            rchk("tdh", `TRX_OFS_TDH, {26'h0, tdh});
            rchk("timer0_mode_reg", `TRX_OFS_TIMER0_MODE_REG, {24'h0, timer0_mode_reg});
            rchk("status", `TRX_OFS_STATUS, {30'h0, zf, 1'b0});
            rchk("file", fadr, {24'h0, fv});
            rchk("tph", `TRX_OFS_TPH, {24'h0, tph});
        end
        wrap_up();
    end
endmodule : tb
`default_nettype wire

/* File: verification/trx_monitor.sv */
// concurrent checks on the bus and rom ports of the execution slice
`timescale 1ns/10ps
`default_nettype none
`include "trx_regs.svh"

module trx_monitor #(
    parameter int ROM_AW = 11
) (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic [11:0]       s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [3:0]        s_axi_wstrb,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [11:0]       s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [ROM_AW-1:0] rom_addr,
    input wire logic              rom_rd,
    input wire logic [13:0]       rom_data
);
    logic [2:0] tph_r;
    logic [2:0] tph_nxt;
    logic       ar_hit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------------
    // shadow of the table pointer, taken from bus writes
    // ------------------------------------------------------------------------
    always_comb begin
        tph_nxt = tph_r;
        if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == `TRX_OFS_TPH && s_axi_wstrb[0]) begin
            tph_nxt = s_axi_wdata[2:0];
        end
    end
    always_ff @(posedge clk) begin
        tph_r <= sys_rst ? 3'h0 : tph_nxt;
    end
    assign ar_hit = s_axi_arvalid && s_axi_arready;

    // ------------------------------------------------------------------------
    // sequences and assertions
    // ------------------------------------------------------------------------
    sequence wr_pair;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rom_fetch;
        rom_rd ##1 !rom_rd;
    endsequence

    chk_rom_strobe: assert property (rom_rd |-> rom_fetch)
        else $error("rom strobe longer than one cycle");
    chk_rom_addr_hi: assert property (
        rom_rd |-> rom_addr[ROM_AW-1:ROM_AW-3] == tph_r)
        else $error("rom address upper bits differ from table pointer");
    chk_write_answer: assert property (wr_pair |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    chk_write_single: assert property (wr_pair |=> !s_axi_awready && !s_axi_wready)
        else $error("second write accepted while one is held");
    chk_bad_wr_resp: assert property (wr_pair ##0 s_axi_awaddr inside {[12'h018:12'h1FC]}
        |-> ##[1:4] s_axi_bvalid && s_axi_bresp == `TRX_RESP_SLVERR)
        else $error("unmapped write not refused");
    chk_read_answer: assert property (ar_hit |=> s_axi_rvalid)
        else $error("read data late");
    chk_ar_gate: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    chk_read_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data still offered after it was taken");
    chk_bad_rd_resp: assert property (ar_hit && s_axi_araddr inside {[12'h018:12'h1FC]}
        |=> s_axi_rresp == `TRX_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    chk_status_pad: assert property (ar_hit && s_axi_araddr == `TRX_OFS_STATUS
        |=> s_axi_rdata[31:2] == 30'h0)
        else $error("status upper bits not zero");
endmodule : trx_monitor

bind trx_core trx_monitor #(.ROM_AW(ROM_AW)) u_mon (.*);
`default_nettype wire

/* File: verilog/trx_core.sv */
// table-read / timer-mode / xor execution slice with an axi4-lite register port
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
`include "trx_regs.svh"

module trx_core
    import trx_pkg::*;
#(
    parameter int ROM_AW     = 11,
    parameter int FILE_DEPTH = 128
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [ROM_AW-1:0]      rom_addr,
    output logic                   rom_rd,
    input  wire logic [13:0]       rom_data
);

    // ------------------------------------------------------------------------
    // elaboration checks and helpers
    // ------------------------------------------------------------------------
    if (ROM_AW != 11) begin : g_bad_rom_aw
        $error("trx_core: ROM_AW must be 11");
    end
    if (FILE_DEPTH < 1 || FILE_DEPTH > 128) begin : g_bad_depth
        $error("trx_core: FILE_DEPTH must be 1 to 128");
    end

    // merge a bus word into an old word under the byte strobes
    function automatic logic [31:0] strb_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : strb_merge

    // file register window hit
    function automatic logic file_hit(input logic [11:0] a);
        return (a >= `TRX_OFS_FILE_BASE) && (a <= `TRX_OFS_FILE_LAST)
            && (32'(a[8:2]) < FILE_DEPTH);
    endfunction : file_hit

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    trx_state_e        state_r,  state_nxt;
    trx_byte_t         acc_r,    acc_nxt;
    trx_byte_t         tph_r,    tph_nxt;
    logic [5:0]        tdh_r,    tdh_nxt;
    trx_byte_t         timer0_mode_reg_r,   timer0_mode_reg_nxt;
    logic              zero_r,   zero_nxt;
    logic [23:0]       cmd_r,    cmd_nxt;
    logic [ROM_AW-1:0] raddr_r,  raddr_nxt;
    logic              rrd_r,    rrd_nxt;
    logic              awrdy_r,   awrdy_nxt;
    logic [11:0]       aw_addr_r, aw_addr_nxt;
    logic              wrdy_r,    wrdy_nxt;
    logic [31:0]       w_data_r,  w_data_nxt;
    logic [3:0]        w_strb_r,  w_strb_nxt;
    logic              bvalid_r,  bvalid_nxt;
    logic [1:0]        bresp_r,   bresp_nxt;
    logic              rvalid_r,  rvalid_nxt;
    logic [31:0]       rdata_r,   rdata_nxt;
    logic [1:0]        rresp_r,   rresp_nxt;
    logic              arrdy_r,   arrdy_nxt;

    trx_byte_t         file_mem [FILE_DEPTH];
    logic              fwe;
    logic [6:0]        fwa;
    trx_byte_t         fwd;

    // ------------------------------------------------------------------------
    // bus write, instruction execution and rom sequencing
    // ------------------------------------------------------------------------
    logic        wr_go;
    logic [31:0] wm;
    logic [2:0]  op;
    logic [6:0]  faddr;
    trx_byte_t   imm;
    trx_byte_t   xres;

    always_comb begin
        wm          = 32'h0000_0000;
        op          = `TRX_OP_NOP;
        faddr       = 7'h00;
        imm         = `TRX_RST_BYTE;
        xres        = `TRX_RST_BYTE;
        state_nxt   = state_r;
        acc_nxt     = acc_r;
        tph_nxt     = tph_r;
        tdh_nxt     = tdh_r;
        timer0_mode_reg_nxt    = timer0_mode_reg_r;
        zero_nxt    = zero_r;
        cmd_nxt     = cmd_r;
        raddr_nxt   = raddr_r;
        rrd_nxt     = 1'b0;
        awrdy_nxt   = awrdy_r;
        aw_addr_nxt = aw_addr_r;
        wrdy_nxt    = wrdy_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        fwe         = 1'b0;
        fwa         = 7'h00;
        fwd         = `TRX_RST_BYTE;
        // address and data channels latch independently
        if (s_axi_awvalid && awrdy_r) begin
            awrdy_nxt   = 1'b0;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wrdy_r) begin
            wrdy_nxt   = 1'b0;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        // writes wait while a table read is in flight
        wr_go = !awrdy_r && !wrdy_r && !bvalid_r && (state_r == TRX_IDLE);
        case (state_r)
            TRX_IDLE: begin
                if (wr_go) begin
                    awrdy_nxt   = 1'b1;
                    wrdy_nxt    = 1'b1;
                    bvalid_nxt  = 1'b1;
                    bresp_nxt   = `TRX_RESP_OKAY;
                    if (aw_addr_r == `TRX_OFS_CMD) begin
                        wm      = strb_merge({8'h00, cmd_r}, w_data_r, w_strb_r);
                        cmd_nxt = wm[23:0];
                        op      = wm[`TRX_CMD_OP_MSB:`TRX_CMD_OP_LSB];
                        faddr   = wm[`TRX_CMD_FADDR_MSB:`TRX_CMD_FADDR_LSB];
                        imm     = wm[`TRX_CMD_IMM_MSB:`TRX_CMD_IMM_LSB];
                        case (op)
                            `TRX_OP_TABLE_READ: begin
                                raddr_nxt = {tph_r[`TRX_TPH_USED_MSB:0], acc_r};
                                rrd_nxt   = 1'b1;
                                state_nxt = TRX_ROM_ISSUE;
                            end
                            `TRX_OP_TMODE_READ: begin
                                acc_nxt = timer0_mode_reg_r;
                            end
                            `TRX_OP_TMODE_WRITE: begin
                                timer0_mode_reg_nxt = acc_r;
                            end
                            `TRX_OP_XOR_REG: begin
                                xres = acc_r ^ file_mem[faddr];
                                if (wm[`TRX_CMD_DEST_BIT]) begin
                                    fwe = 1'b1;
                                    fwa = faddr;
                                    fwd = xres;
                                end else begin
                                    acc_nxt = xres;
                                end
                            end
                            `TRX_OP_XOR_IMM: begin
                                xres     = acc_r ^ imm;
                                acc_nxt  = xres;
                                zero_nxt = (xres == `TRX_RST_BYTE);
                            end
                            default: ;
                        endcase
                    end else if (aw_addr_r == `TRX_OFS_ACC) begin
                        wm      = strb_merge({24'h0, acc_r}, w_data_r, w_strb_r);
                        acc_nxt = wm[7:0];
                    end else if (aw_addr_r == `TRX_OFS_TPH) begin
                        wm      = strb_merge({24'h0, tph_r}, w_data_r, w_strb_r);
                        tph_nxt = wm[7:0];
                    end else if (aw_addr_r == `TRX_OFS_TDH) begin
                        wm      = strb_merge({26'h0, tdh_r}, w_data_r, w_strb_r);
                        tdh_nxt = wm[5:0];
                    end else if (aw_addr_r == `TRX_OFS_TIMER0_MODE_REG
                                 || aw_addr_r == `TRX_OFS_STATUS) begin
                        bresp_nxt = `TRX_RESP_OKAY; // read-only, write ignored
                    end else if (file_hit(aw_addr_r)) begin
                        wm  = strb_merge({24'h0, file_mem[aw_addr_r[8:2]]},
                                         w_data_r, w_strb_r);
                        fwe = 1'b1;
                        fwa = aw_addr_r[8:2];
                        fwd = wm[7:0];
                    end else begin
                        bresp_nxt = `TRX_RESP_SLVERR;
                    end
                end
            end
            TRX_ROM_ISSUE: begin
                state_nxt = TRX_ROM_TAKE; // rom answers one cycle after the strobe
            end
            TRX_ROM_TAKE: begin
                acc_nxt   = rom_data[`TRX_ROM_LOW_MSB:0];
                tdh_nxt   = rom_data[`TRX_ROM_HIGH_MSB:`TRX_ROM_HIGH_LSB];
                state_nxt = TRX_IDLE;
            end
            default: begin
                state_nxt = TRX_IDLE;
            end
        endcase
    end

    // bus read path; arready is kept in a flop of its own
    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `TRX_RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            if (s_axi_araddr == `TRX_OFS_CMD) begin
                rdata_nxt = {8'h00, cmd_r};
            end else if (s_axi_araddr == `TRX_OFS_ACC) begin
                rdata_nxt = {24'h0, acc_r};
            end else if (s_axi_araddr == `TRX_OFS_TPH) begin
                rdata_nxt = {24'h0, tph_r};
            end else if (s_axi_araddr == `TRX_OFS_TDH) begin
                rdata_nxt = {26'h0, tdh_r};
            end else if (s_axi_araddr == `TRX_OFS_TIMER0_MODE_REG) begin
                rdata_nxt = {24'h0, timer0_mode_reg_r};
            end else if (s_axi_araddr == `TRX_OFS_STATUS) begin
                rdata_nxt[`TRX_STAT_BUSY_BIT] = (state_r != TRX_IDLE);
                rdata_nxt[`TRX_STAT_ZERO_BIT] = zero_r;
            end else if (file_hit(s_axi_araddr)) begin
                rdata_nxt = {24'h0, file_mem[s_axi_araddr[8:2]]};
            end else begin
                rresp_nxt = `TRX_RESP_SLVERR;
            end
        end
        arrdy_nxt = !rvalid_nxt;
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r   <= TRX_IDLE;
            acc_r     <= `TRX_RST_BYTE;
            tph_r     <= `TRX_RST_BYTE;
            tdh_r     <= `TRX_RST_TDH;
            timer0_mode_reg_r    <= `TRX_RST_BYTE;
            zero_r    <= 1'b0;
            cmd_r     <= 24'h000000;
            raddr_r   <= '0;
            rrd_r     <= 1'b0;
            awrdy_r   <= 1'b1;
            aw_addr_r <= 12'h000;
            wrdy_r    <= 1'b1;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `TRX_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `TRX_RESP_OKAY;
            arrdy_r   <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            acc_r     <= acc_nxt;
            tph_r     <= tph_nxt;
            tdh_r     <= tdh_nxt;
            timer0_mode_reg_r    <= timer0_mode_reg_nxt;
            zero_r    <= zero_nxt;
            cmd_r     <= cmd_nxt;
            raddr_r   <= raddr_nxt;
            rrd_r     <= rrd_nxt;
            awrdy_r   <= awrdy_nxt;
            aw_addr_r <= aw_addr_nxt;
            wrdy_r    <= wrdy_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            arrdy_r   <= arrdy_nxt;
        end
    end

    // file registers hold no reset; software clears them as needed
    always_ff @(posedge clk) begin
        if (fwe) begin
            file_mem[fwa] <= fwd;
        end
    end

    // outputs come straight from the flops
    assign s_axi_awready = awrdy_r;
    assign s_axi_wready  = wrdy_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arrdy_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign rom_addr      = raddr_r;
    assign rom_rd        = rrd_r;

endmodule : trx_core
`default_nettype wire

/* File: verilog/trx_pkg.sv */
// types shared by the table-read / xor execution slice
package trx_pkg;

    // ------------------------------------------------------------------------
    // execution sequencer states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        TRX_IDLE,
        TRX_ROM_ISSUE,
        TRX_ROM_TAKE
    } trx_state_e;

    typedef logic [7:0] trx_byte_t;

endpackage : trx_pkg

/* File: verilog/trx_regs.svh */
// register offsets, field positions and reset values of the table-read / xor slice
`ifndef TRX_REGS_SVH
`define TRX_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define TRX_OFS_CMD          12'h000
`define TRX_OFS_ACC          12'h004
`define TRX_OFS_TPH          12'h008
`define TRX_OFS_TDH          12'h00C
`define TRX_OFS_TIMER0_MODE_REG         12'h010
`define TRX_OFS_STATUS       12'h014
`define TRX_OFS_FILE_BASE    12'h200
`define TRX_OFS_FILE_LAST    12'h3FC

// ----------------------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------------------
`define TRX_CMD_OP_LSB       0
`define TRX_CMD_OP_MSB       2
`define TRX_CMD_DEST_BIT     3
`define TRX_CMD_FADDR_LSB    8
`define TRX_CMD_FADDR_MSB    14
`define TRX_CMD_IMM_LSB      16
`define TRX_CMD_IMM_MSB      23

// ----------------------------------------------------------------------------
// instruction codes
// ----------------------------------------------------------------------------
`define TRX_OP_NOP           3'h0
`define TRX_OP_TABLE_READ    3'h1
`define TRX_OP_TMODE_READ    3'h2
`define TRX_OP_TMODE_WRITE   3'h3
`define TRX_OP_XOR_REG       3'h4
`define TRX_OP_XOR_IMM       3'h5

// ----------------------------------------------------------------------------
// status fields, table-pointer width, rom word split
// ----------------------------------------------------------------------------
`define TRX_STAT_BUSY_BIT    0
`define TRX_STAT_ZERO_BIT    1
`define TRX_TPH_USED_MSB     2
`define TRX_ROM_LOW_MSB      7
`define TRX_ROM_HIGH_LSB     8
`define TRX_ROM_HIGH_MSB     13

// ----------------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------------
`define TRX_RST_BYTE         8'h00
`define TRX_RST_TDH          6'h00
`define TRX_RESP_OKAY        2'h0
`define TRX_RESP_SLVERR      2'h2

`endif
